// *** hw/host_port_params.svh ***
// Constants of the indirect host register port: port codes, fields, resets, cycle counts.
// Assumes inclusion by bare name from the package and the port module.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define PORT_INDEX       3'h0
`define PORT_STATUS      3'h1
`define PORT_DATA        3'h2
`define INDEX_RW_BIT     0
`define INDEX_RW_READ    1'b1
`define STATUS_WC_BIT    8
`define STATUS_MEM_BIT   0
`define DATA_RESET       16'h0000
`define INDEX_RESET      16'h0000
`define WRITE_CYCLE_CLKS 3
`endif

// *** hw/host_port_pkg.sv ***
// Types shared by the indirect host register port.
// Assumes the constants header is on the include path.
`include "host_port_params.svh"
package host_port_pkg;
    typedef logic [2:0]  port_sel_t;
    typedef logic [15:0] word_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } access_state_e;
endpackage : host_port_pkg

// *** hw/indirect_register_host_port.sv ***
// Indirect 16-bit host port: index, data and status ports onto an internal register bus.
// Assumes host strobes are one-cycle pulses synchronous to core_clk, and that the
// internal register set answers a read combinationally in the cycle of intRdEn.
`timescale 1ns/1ps
`include "host_port_params.svh"
module indirect_register_host_port #(
    parameter int DATA_W = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire host_port_pkg::port_sel_t portSelectLines,
    input  wire logic                   hostWrStrobe,
    input  wire logic                   hostRdStrobe,
    input  wire host_port_pkg::word_t   hostWrData,
    output host_port_pkg::word_t        hostRdData,
    output logic                        hostRdValid,
    input  wire logic                   writeCtrlBusy,
    input  wire logic                   memCtrlBusy,
    output host_port_pkg::word_t        intAddr,
    output logic                        intWrEn,
    output host_port_pkg::word_t        intWrData,
    output logic                        intRdEn,
    input  wire host_port_pkg::word_t   intRdData
);
    import host_port_pkg::*;

    if (DATA_W != 16) begin : g_width_check
        $error("DATA_W must be 16");
    end

    access_state_e stateReg;
    access_state_e stateNext;
    word_t         indexReg;
    word_t         indexNext;
    word_t         dataPortReg;
    word_t         dataPortNext;
    word_t         rdDataReg;
    word_t         rdDataNext;
    logic          rdValidReg;
    logic          rdValidNext;
    logic          wrIndex;
    logic          wrData;
    logic          rdStatusSel;
    logic          wrStatus;

    function automatic logic portHit(input port_sel_t sel, input port_sel_t code);
        portHit = (sel == code);
    endfunction : portHit

    assign wrIndex     = hostWrStrobe && portHit(portSelectLines, `PORT_INDEX);
    assign wrData      = hostWrStrobe && portHit(portSelectLines, `PORT_DATA);
    assign wrStatus    = hostWrStrobe && portHit(portSelectLines, `PORT_STATUS);
    assign rdStatusSel = portHit(portSelectLines, `PORT_STATUS);

    always_comb begin
        stateNext    = ST_IDLE;
        indexNext    = indexReg;
        dataPortNext = dataPortReg;
        rdDataNext   = rdDataReg;
        rdValidNext  = hostRdStrobe;
        if (wrIndex) begin
            indexNext = hostWrData;
        end
        unique case (stateReg)
            ST_IDLE: begin
            end
            ST_WRITE: begin
            end
            ST_READ: begin
                dataPortNext = intRdData;
            end
        endcase
        if (wrData) begin
            dataPortNext = hostWrData;
            if (indexReg[`INDEX_RW_BIT] != `INDEX_RW_READ) begin
                stateNext = ST_WRITE;
            end
        end else if (wrIndex && hostWrData[`INDEX_RW_BIT] == `INDEX_RW_READ) begin
            stateNext = ST_READ;
        end
        if (hostRdStrobe) begin
            rdDataNext = '0;
            if (portHit(portSelectLines, `PORT_INDEX)) begin
                rdDataNext = indexReg;
            end else if (portHit(portSelectLines, `PORT_DATA)) begin
                rdDataNext = dataPortReg;
            end else if (rdStatusSel) begin
                rdDataNext[`STATUS_WC_BIT]  = writeCtrlBusy;
                rdDataNext[`STATUS_MEM_BIT] = memCtrlBusy;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stateReg    <= ST_IDLE;
            indexReg    <= `INDEX_RESET;
            dataPortReg <= `DATA_RESET;
            rdDataReg   <= '0;
            rdValidReg  <= 1'b0;
        end else begin
            stateReg    <= stateNext;
            indexReg    <= indexNext;
            dataPortReg <= dataPortNext;
            rdDataReg   <= rdDataNext;
            rdValidReg  <= rdValidNext;
        end
    end

    // Status writes fall through every branch above
    assign intAddr    = {indexReg[15:1], 1'b0};
    assign intWrEn    = (stateReg == ST_WRITE);
    assign intWrData  = dataPortReg;
    assign intRdEn    = (stateReg == ST_READ);
    assign hostRdData = rdDataReg;
    assign hostRdValid = rdValidReg;

    // Checks
    property p_index_addr;
        @(posedge core_clk) disable iff (!resetn)
        wrIndex |=> intAddr == {$past(hostWrData[15:1]), 1'b0};
    endproperty
    a_index_addr: assert property (p_index_addr) else $error("index address not taken");

    property p_dir_read;
        @(posedge core_clk) disable iff (!resetn)
        (wrIndex && !wrData && hostWrData[0]) |=> intRdEn ##1 !intRdEn;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("read not launched once");

    property p_dir_write;
        @(posedge core_clk) disable iff (!resetn)
        (wrIndex && !hostWrData[0]) |=> !intRdEn;
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("read launched on write index");

    property p_data_store;
        @(posedge core_clk) disable iff (!resetn)
        wrData |=> dataPortReg == $past(hostWrData);
    endproperty
    a_data_store: assert property (p_data_store) else $error("data port not stored");

    property p_write_issue;
        @(posedge core_clk) disable iff (!resetn)
        (wrData && !wrIndex && !indexReg[0])
            |=> intWrEn && intWrData == $past(hostWrData) && intAddr == $past(intAddr);
    endproperty
    a_write_issue: assert property (p_write_issue) else $error("internal write wrong");

    property p_write_rate;
        @(posedge core_clk) disable iff (!resetn)
        (wrData && !indexReg[0]) ##3 (wrData && !indexReg[0]) |=> intWrEn;
    endproperty
    a_write_rate: assert property (p_write_rate) else $error("3-clock write lost");

    property p_status_wc;
        @(posedge core_clk) disable iff (!resetn)
        (hostRdStrobe && rdStatusSel) |=> hostRdValid && hostRdData[8] == $past(writeCtrlBusy);
    endproperty
    a_status_wc: assert property (p_status_wc) else $error("write controller flag wrong");

    property p_status_mem;
        @(posedge core_clk) disable iff (!resetn)
        (hostRdStrobe && rdStatusSel) |=> hostRdData[0] == $past(memCtrlBusy);
    endproperty
    a_status_mem: assert property (p_status_mem) else $error("memory flag wrong");

    property p_status_zero;
        @(posedge core_clk) disable iff (!resetn)
        (hostRdStrobe && rdStatusSel) |=> hostRdData[15:9] == '0 && hostRdData[7:1] == '0;
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("unused status bits set");

    property p_status_wr_ignored;
        @(posedge core_clk) disable iff (!resetn)
        wrStatus |=> $stable(intAddr) && !intWrEn && !intRdEn;
    endproperty
    a_status_wr_ignored: assert property (p_status_wr_ignored) else $error("status write acted");

    property p_read_capture;
        @(posedge core_clk) disable iff (!resetn)
        (intRdEn && !wrData) |=> dataPortReg == $past(intRdData);
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read data not captured");

    property p_rd_valid;
        @(posedge core_clk) disable iff (!resetn)
        hostRdStrobe |=> hostRdValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");

    property p_rd_valid_idle;
        @(posedge core_clk) disable iff (!resetn)
        !hostRdStrobe |=> !hostRdValid;
    endproperty
    a_rd_valid_idle: assert property (p_rd_valid_idle) else $error("spurious read answer");

    property p_data_read;
        @(posedge core_clk) disable iff (!resetn)
        (hostRdStrobe && portHit(portSelectLines, `PORT_DATA))
            |=> hostRdData == $past(dataPortReg);
    endproperty
    a_data_read: assert property (p_data_read) else $error("data port read wrong");

    property p_unmapped_zero;
        @(posedge core_clk) disable iff (!resetn)
        (hostRdStrobe && portSelectLines > `PORT_DATA) |=> hostRdData == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_write_cause;
        @(posedge core_clk) disable iff (!resetn)
        intWrEn |-> $past(wrData);
    endproperty
    a_write_cause: assert property (p_write_cause) else $error("internal write uncaused");

    c_write: cover property (@(posedge core_clk) disable iff (!resetn) wrData ##1 intWrEn);
    c_read: cover property (@(posedge core_clk) disable iff (!resetn)
        intRdEn ##1 (hostRdStrobe && portHit(portSelectLines, `PORT_DATA)));
    c_status: cover property (@(posedge core_clk) disable iff (!resetn)
        wrData ##2 (hostRdStrobe && rdStatusSel));
    c_b2b: cover property (@(posedge core_clk) disable iff (!resetn) intWrEn ##3 intWrEn);

endmodule : indirect_register_host_port

// *** testbench/host_model.sv ***
// Host processor model: issues index, data and status port cycles.
// Assumes one-cycle strobes taken at core_clk rising edges.
`timescale 1ns/1ps
module host_model (
    input  wire logic                     core_clk,
    output host_port_pkg::port_sel_t      portSelectLines,
    output logic                          hostWrStrobe,
    output logic                          hostRdStrobe,
    output host_port_pkg::word_t          hostWrData,
    input  wire host_port_pkg::word_t     hostRdData,
    input  wire logic                     hostRdValid
);
    import host_port_pkg::*;
    initial begin
        portSelectLines = 3'h0;
        hostWrStrobe = 1'b0;
        hostRdStrobe = 1'b0;
        hostWrData = 16'h0;
    end
    task automatic wr(input port_sel_t s, input word_t d);
        @(posedge core_clk);
        portSelectLines <= s;
        hostWrData <= d;
        hostWrStrobe <= 1'b1;
        @(posedge core_clk);
        hostWrStrobe <= 1'b0;
        hostWrData <= ~d;
    endtask : wr
    task automatic rd(input port_sel_t s, output word_t d);
        @(posedge core_clk);
        portSelectLines <= s;
        hostRdStrobe <= 1'b1;
        @(posedge core_clk);
        hostRdStrobe <= 1'b0;
        @(posedge core_clk);
        d = (hostRdValid === 1'b1) ? hostRdData : 'x;
    endtask : rd
endmodule : host_model

// *** testbench/testbench.sv ***
// Self-checking bench for the indirect host register port.
// Assumes a 16-entry internal register set answering in the read cycle.
`timescale 1ns/1ps
`include "host_port_params.svh"
module testbench;
    import host_port_pkg::*;
    logic      core_clk, resetn, hostWrStrobe, hostRdStrobe, hostRdValid;
    logic      writeCtrlBusy, memCtrlBusy, intWrEn, intRdEn;
    port_sel_t portSelectLines;
    word_t     hostWrData, hostRdData, intAddr, intWrData, intRdData, v;
    word_t     mem [16];
    int        errCount, checksDone, wrCount, cycles;
    indirect_register_host_port indirect_register_host_port_i (.core_clk, .resetn,
        .portSelectLines, .hostWrStrobe, .hostRdStrobe, .hostWrData, .hostRdData,
        .hostRdValid, .writeCtrlBusy, .memCtrlBusy, .intAddr, .intWrEn, .intWrData,
        .intRdEn, .intRdData);
    host_model host_model_i (.core_clk, .portSelectLines, .hostWrStrobe,
        .hostRdStrobe, .hostWrData, .hostRdData, .hostRdValid);
    // Outside the read cycle the internal bus shows a wrong value
    assign intRdData = intRdEn ? mem[intAddr[4:1]] : ~mem[intAddr[4:1]];
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (intWrEn === 1'b1) begin
            mem[intAddr[4:1]] <= intWrData;
            wrCount <= wrCount + 1;
        end
        if (cycles == 3000) begin
            errCount++;
            stop_test();
        end
    end
    task automatic check(input word_t seen, input word_t exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic t_reset();
        check(word_t'(intWrEn), 16'h0);
        check(intAddr, 16'h0);
        check(intWrData, `DATA_RESET);
        check(hostRdData, 16'h0000);
        host_model_i.rd(`PORT_DATA, v);
        check(v, `DATA_RESET);
        host_model_i.rd(`PORT_INDEX, v);
        check(v, `INDEX_RESET);
    endtask : t_reset
    task automatic t_write();
        for (int i = 1; i < 5; i++) begin
            host_model_i.wr(`PORT_INDEX, word_t'(i * 2));
            @(negedge core_clk);
            check(intAddr, word_t'(i * 2));
            host_model_i.wr(`PORT_DATA, word_t'(i * 16'h1111));
            if (i % 2 == 1) begin
                host_model_i.rd(`PORT_STATUS, v);
                check(v, 16'h0000);
            end else begin
                @(posedge core_clk);
                @(negedge core_clk);
            end
            check(mem[i], word_t'(i * 16'h1111));
        end
        check(word_t'(wrCount), 16'h4);
        host_model_i.wr(`PORT_INDEX, 16'h000C);
        host_model_i.wr(`PORT_DATA, 16'hA5A5);
        @(posedge core_clk);
        host_model_i.wr(`PORT_DATA, 16'h5A5A);
        repeat (2) @(posedge core_clk);
        check(mem[6], 16'h5A5A);
        check(word_t'(wrCount), 16'h6);
    endtask : t_write
    task automatic t_read();
        for (int i = 4; i > 0; i--) begin
            host_model_i.wr(`PORT_INDEX, word_t'(i * 2 + 1));
            host_model_i.rd(`PORT_DATA, v);
            check(v, word_t'(i * 16'h1111));
        end
        check(word_t'(wrCount), 16'h6);
    endtask : t_read
    task automatic t_refused();
        host_model_i.wr(`PORT_INDEX, 16'h000B);
        host_model_i.wr(`PORT_DATA, 16'h1234);
        repeat (2) @(posedge core_clk);
        check(word_t'(wrCount), 16'h6);
        host_model_i.rd(`PORT_DATA, v);
        check(v, 16'h1234);
        host_model_i.wr(`PORT_STATUS, 16'hFFFF);
        host_model_i.wr(3'h7, 16'hFFFF);
        host_model_i.rd(3'h7, v);
        check(v, 16'h0000);
        check(word_t'(wrCount), 16'h6);
        host_model_i.rd(`PORT_INDEX, v);
        check(v, 16'h000B);
        check(mem[5], 16'h0005);
    endtask : t_refused
    task automatic t_status();
        for (int k = 0; k < 4; k++) begin
            writeCtrlBusy <= k[1];
            memCtrlBusy <= k[0];
            host_model_i.rd(`PORT_STATUS, v);
            check(v, {7'h0, k[1], 7'h0, k[0]});
        end
    endtask : t_status
    task automatic t_midreset();
        host_model_i.wr(`PORT_INDEX, 16'h0006);
        resetn <= 1'b0;
        @(negedge core_clk);
        check(intAddr, 16'h0000);
        check(hostRdData, 16'h0000);
        @(posedge core_clk);
        resetn <= 1'b1;
        host_model_i.rd(`PORT_INDEX, v);
        check(v, `INDEX_RESET);
    endtask : t_midreset
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        resetn = 1'b0;
        writeCtrlBusy = 1'b0;
        memCtrlBusy = 1'b0;
        errCount = 0;
        checksDone = 0;
        wrCount = 0;
        cycles = 0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = word_t'(i);
        end
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_write();
        t_read();
        t_refused();
        t_status();
        t_midreset();
        stop_test();
    end
endmodule : testbench
